// ===== src/timer_control_pkg.sv
/*
 Constants shared by the timer control block: register offsets, field positions,
 reset values and mode encodings. Assumes a 16-bit counter on a 32-bit AHB-Lite bus.
*/
// Behaviour
// - Run-enable bit 0 starts the counter when set and halts it when cleared.
// - In trigger mode a hardware trigger sets run-enable without software.
// - Update-inhibit bit 1 suppresses every update event while set.
// - Updates come from wrap, the software update trigger, or the slave controller.
// - Each update event moves buffered reload, prescale and compare into active copies.
// - Request-source bit 2 limits update requests to wrap events when set.
// - One-shot bit 3 clears run-enable at the next update, which stops the counter.
// - Direction bit 4 selects up or down; read-only in center or encoder mode.
// - Alignment field 6:5: edge, or center with compare flag down, up, or both.
// - Center modes alternate up and down; edge mode keeps the chosen direction.
// - Reload-preload bit 7 makes reload writes wait for the next update event.
// - Divider field 9:8 gives a filter tick of one, two or four clocks.
// - Control register sits at offset zero and resets to all zeros.
package timer_control_pkg;

	localparam int CNT_W = 16;

	localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_EVENT_GEN = 8'h14;
	localparam logic [7:0] OFF_COUNTER = 8'h24;
	localparam logic [7:0] OFF_PRESCALE = 8'h28;
	localparam logic [7:0] OFF_RELOAD = 8'h2c;
	localparam logic [7:0] OFF_COMPARE = 8'h34;

	localparam int BIT_RUN = 0;
	localparam int BIT_INHIBIT = 1;
	localparam int BIT_URS = 2;
	localparam int BIT_ONE_SHOT = 3;
	localparam int BIT_DIR = 4;
	localparam int ALIGN_LO = 5;
	localparam int ALIGN_HI = 6;
	localparam int BIT_PRELOAD = 7;
	localparam int DIV_LO = 8;
	localparam int DIV_HI = 9;

	localparam logic [15:0] CONTROL_ONE_RESET = 16'h0000;
	localparam logic [15:0] CONTROL_ONE_MASK = 16'h03ff;

	localparam int BIT_UPDATE_FLAG = 0;
	localparam int BIT_COMPARE_FLAG = 1;
	localparam logic [1:0] STATUS_RESET = 2'h0;
	localparam int BIT_SW_UPDATE = 0;

	localparam logic [15:0] PRESCALE_RESET = 16'h0000;
	localparam logic [15:0] RELOAD_RESET = 16'hffff;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;

	localparam logic [1:0] DIV_ONE = 2'h0;
	localparam logic [1:0] DIV_TWO = 2'h1;
	localparam logic [1:0] DIV_FOUR = 2'h2;
	localparam logic [1:0] DIV_RESERVED = 2'h3;

	typedef enum logic [1:0] {
		ALIGN_EDGE = 2'h0,
		ALIGN_FLAG_DOWN = 2'h1,
		ALIGN_FLAG_UP = 2'h2,
		ALIGN_FLAG_BOTH = 2'h3
	} align_t;

endpackage

// ===== src/dead_filter_tick_divider.sv
/*
 Divider that makes the dead-time and filter sampling tick from the kernel clock.
 Assumes the divide code never holds the reserved value; it falls back to four.
*/
`timescale 1ns/10ps
`default_nettype none
module dead_filter_tick_divider
	import timer_control_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Control.
	input wire logic [1:0] divide_code,
	// Tick.
	output logic tick
);
	logic [1:0] count;
	logic [1:0] next_count;
	logic [1:0] limit;
	logic next_tick;

	always_comb begin
		if (divide_code == DIV_ONE) begin
			limit = 2'h0;
		end else if (divide_code == DIV_TWO) begin
			limit = 2'h1;
		end else begin
			limit = 2'h3;
		end
		if (count >= limit) begin
			next_count = 2'h0;
			next_tick = 1'b1;
		end else begin
			next_count = count + 2'h1;
			next_tick = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 2'h0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule
`default_nettype wire

// ===== src/buffered_value_register.sv
/*
 A value with a buffered copy and an active copy. Writes go straight to the
 active copy unless buffering is on; a load moves the buffered copy across.
*/
`timescale 1ns/10ps
`default_nettype none
module buffered_value_register
	import timer_control_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = 16'h0000
)
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Write side.
	input wire logic write_strobe,
	input wire logic [15:0] write_data,
	input wire logic buffered,
	input wire logic load,
	// Copies.
	output logic [15:0] preload_value,
	output logic [15:0] active_value
);
	logic [15:0] next_preload;
	logic [15:0] next_active;

	always_comb begin
		next_preload = write_strobe ? write_data : preload_value;
		next_active = active_value;
		if (write_strobe && !buffered) begin
			next_active = write_data;
		end else if (load) begin
			next_active = next_preload;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			preload_value <= RESET_VALUE;
			active_value <= RESET_VALUE;
		end else begin
			preload_value <= next_preload;
			active_value <= next_active;
		end
	end
endmodule
`default_nettype wire

// ===== src/timer_counter_control_one.sv
/*
 Timer counter with its first control register, reached over AHB-Lite.
 Assumes one AHB-Lite master, whole-word single transfers, and a slave-mode
 controller outside that reports its mode and pulses its trigger and update.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_counter_control_one
	import timer_control_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Slave-mode controller.
	input wire logic trigger_mode_active,
	input wire logic encoder_mode_active,
	input wire logic trigger_start,
	input wire logic slave_update,
	// Timer outputs.
	output logic [15:0] counter_value,
	output logic count_down,
	output logic counter_update_event,
	output logic update_request,
	output logic compare_flag,
	output logic channel_output,
	output logic dead_filter_tick
);
	// Bus state.
	logic wr_pending;
	logic [7:0] wr_addr;
	logic next_wr_pending;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic take;

	// Register state.
	logic [15:0] control_one;
	logic [15:0] next_control_one;
	logic [1:0] status;
	logic [1:0] next_status;

	// Counter state.
	logic [15:0] prescale_count;
	logic [15:0] next_prescale_count;
	logic [15:0] next_counter;
	logic next_dir;
	logic wrap;
	logic stepped;
	logic compare_hit;
	logic update_now;
	logic request_now;
	logic next_channel;

	// Decoded fields.
	logic counter_run_enable;
	logic update_inhibit;
	logic update_request_source;
	logic one_shot_enable;
	logic count_direction;
	align_t center_align_select;
	logic reload_preload_enable;
	logic [1:0] dead_filter_clock_divide;
	logic direction_locked;

	// Write strobes.
	logic wr_control;
	logic wr_status;
	logic software_update_trigger;
	logic wr_prescale;
	logic wr_reload;
	logic wr_compare;

	// Value copies.
	logic [15:0] prescale_pre;
	logic [15:0] prescale_value;
	logic [15:0] reload_pre;
	logic [15:0] reload_value;
	logic [15:0] compare_pre;
	logic [15:0] compare_value;

	function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
		hits = (addr == offset);
	endfunction

	assign counter_run_enable = control_one[BIT_RUN];
	assign update_inhibit = control_one[BIT_INHIBIT];
	assign update_request_source = control_one[BIT_URS];
	assign one_shot_enable = control_one[BIT_ONE_SHOT];
	assign count_direction = control_one[BIT_DIR];
	assign center_align_select = align_t'(control_one[ALIGN_HI:ALIGN_LO]);
	assign reload_preload_enable = control_one[BIT_PRELOAD];
	assign dead_filter_clock_divide = control_one[DIV_HI:DIV_LO];
	assign direction_locked = (center_align_select != ALIGN_EDGE) || encoder_mode_active;

	// The slave never stalls and never errors, so every transfer completes in
	// one data-phase cycle and the master's pipelining is never broken.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	assign take = hsel && htrans[1] && hready;
	assign wr_control = wr_pending && hits(wr_addr, OFF_CONTROL_ONE);
	assign wr_status = wr_pending && hits(wr_addr, OFF_STATUS);
	assign software_update_trigger = wr_pending && hits(wr_addr, OFF_EVENT_GEN)
		&& hwdata[BIT_SW_UPDATE];
	assign wr_prescale = wr_pending && hits(wr_addr, OFF_PRESCALE);
	assign wr_reload = wr_pending && hits(wr_addr, OFF_RELOAD);
	assign wr_compare = wr_pending && hits(wr_addr, OFF_COMPARE);

	// Address phase capture and read data. Reads are sampled at the address
	// phase, so a read that follows a write to the same register at once shows
	// the value from before that write.
	always_comb begin
		next_wr_pending = take && hwrite;
		next_wr_addr = take ? haddr[7:0] : wr_addr;
		next_hrdata = hrdata;
		if (take && !hwrite) begin
			if (hits(haddr[7:0], OFF_CONTROL_ONE)) begin
				next_hrdata = {16'h0000, control_one & CONTROL_ONE_MASK};
			end else if (hits(haddr[7:0], OFF_STATUS)) begin
				next_hrdata = {30'h0, status};
			end else if (hits(haddr[7:0], OFF_COUNTER)) begin
				next_hrdata = {16'h0000, counter_value};
			end else if (hits(haddr[7:0], OFF_PRESCALE)) begin
				next_hrdata = {16'h0000, prescale_pre};
			end else if (hits(haddr[7:0], OFF_RELOAD)) begin
				next_hrdata = {16'h0000, reload_pre};
			end else if (hits(haddr[7:0], OFF_COMPARE)) begin
				next_hrdata = {16'h0000, compare_pre};
			end else begin
				next_hrdata = 32'h00000000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pending <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pending <= next_wr_pending;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
		end
	end

	// Counter and prescaler.
	always_comb begin
		next_prescale_count = prescale_count;
		next_counter = counter_value;
		next_dir = count_direction;
		wrap = 1'b0;
		stepped = 1'b0;
		if (counter_run_enable) begin
			if (prescale_count >= prescale_value) begin
				next_prescale_count = 16'h0000;
				stepped = 1'b1;
				if (center_align_select == ALIGN_EDGE) begin
					if (!count_direction) begin
						if (counter_value >= reload_value) begin
							next_counter = 16'h0000;
							wrap = 1'b1;
						end else begin
							next_counter = counter_value + 16'h0001;
						end
					end else begin
						if (counter_value == 16'h0000) begin
							next_counter = reload_value;
							wrap = 1'b1;
						end else begin
							next_counter = counter_value - 16'h0001;
						end
					end
				end else begin
					if (!count_direction) begin
						if (counter_value >= reload_value) begin
							next_counter = (reload_value == 16'h0000) ? 16'h0000
								: reload_value - 16'h0001;
							next_dir = 1'b1;
							wrap = 1'b1;
						end else begin
							next_counter = counter_value + 16'h0001;
						end
					end else begin
						if (counter_value == 16'h0000) begin
							next_counter = (reload_value == 16'h0000) ? 16'h0000 : 16'h0001;
							next_dir = 1'b0;
							wrap = 1'b1;
						end else begin
							next_counter = counter_value - 16'h0001;
						end
					end
				end
			end else begin
				next_prescale_count = prescale_count + 16'h0001;
			end
		end
		if (!update_inhibit && (software_update_trigger || slave_update)) begin
			// A forced update restarts the count from its starting end.
			next_prescale_count = 16'h0000;
			next_counter = (count_direction && center_align_select == ALIGN_EDGE)
				? reload_value : 16'h0000;
			if (center_align_select != ALIGN_EDGE) begin
				next_dir = 1'b0;
			end
		end
	end

	assign update_now = !update_inhibit && (wrap || software_update_trigger || slave_update);
	assign request_now = update_now && (!update_request_source || wrap);

	always_comb begin
		compare_hit = 1'b0;
		if (stepped && next_counter == compare_value) begin
			case (center_align_select)
				ALIGN_EDGE: begin
					compare_hit = 1'b1;
				end
				ALIGN_FLAG_DOWN: begin
					compare_hit = count_direction;
				end
				ALIGN_FLAG_UP: begin
					compare_hit = !count_direction;
				end
				default: begin
					compare_hit = 1'b1;
				end
			endcase
		end
	end

	// The channel level compares the next counter value with the active compare
	// value, so after one-shot stops the counter it still moves when an update loads a new compare value.
	assign next_channel = (next_counter < compare_value);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale_count <= 16'h0000;
			counter_value <= 16'h0000;
			counter_update_event <= 1'b0;
			update_request <= 1'b0;
			compare_flag <= 1'b0;
			channel_output <= 1'b0;
		end else begin
			prescale_count <= next_prescale_count;
			counter_value <= next_counter;
			counter_update_event <= update_now;
			update_request <= request_now;
			compare_flag <= compare_hit;
			channel_output <= next_channel;
		end
	end

	assign count_down = count_direction;

	// Control register. Hardware set of the run bit wins over a software clear
	// in the same cycle, so a trigger is never lost.
	always_comb begin
		next_control_one = control_one;
		if (wr_control) begin
			next_control_one = hwdata[15:0] & CONTROL_ONE_MASK;
			if (hwdata[DIV_HI:DIV_LO] == DIV_RESERVED) begin
				next_control_one[DIV_HI:DIV_LO] = dead_filter_clock_divide;
			end
			if (direction_locked) begin
				next_control_one[BIT_DIR] = count_direction;
			end
		end
		if (center_align_select != ALIGN_EDGE) begin
			next_control_one[BIT_DIR] = next_dir;
		end
		if (update_now && one_shot_enable) begin
			next_control_one[BIT_RUN] = 1'b0;
		end
		if (trigger_mode_active && trigger_start) begin
			next_control_one[BIT_RUN] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			control_one <= CONTROL_ONE_RESET;
		end else begin
			control_one <= next_control_one;
		end
	end

	// Status flags are cleared by writing zero; a new event in that cycle wins.
	always_comb begin
		next_status = status;
		if (wr_status) begin
			next_status = status & hwdata[1:0];
		end
		if (request_now) begin
			next_status[BIT_UPDATE_FLAG] = 1'b1;
		end
		if (compare_hit) begin
			next_status[BIT_COMPARE_FLAG] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status <= STATUS_RESET;
		end else begin
			status <= next_status;
		end
	end

	// Prescale and compare are always buffered; reload follows the preload bit.
	buffered_value_register #(.RESET_VALUE(PRESCALE_RESET)) prescale_copy (
		.hclk(hclk),
		.hresetn(hresetn),
		.write_strobe(wr_prescale),
		.write_data(hwdata[15:0]),
		.buffered(1'b1),
		.load(update_now),
		.preload_value(prescale_pre),
		.active_value(prescale_value)
	);

	buffered_value_register #(.RESET_VALUE(RELOAD_RESET)) reload_copy (
		.hclk(hclk),
		.hresetn(hresetn),
		.write_strobe(wr_reload),
		.write_data(hwdata[15:0]),
		.buffered(reload_preload_enable),
		.load(update_now),
		.preload_value(reload_pre),
		.active_value(reload_value)
	);

	buffered_value_register #(.RESET_VALUE(COMPARE_RESET)) compare_copy (
		.hclk(hclk),
		.hresetn(hresetn),
		.write_strobe(wr_compare),
		.write_data(hwdata[15:0]),
		.buffered(1'b1),
		.load(update_now),
		.preload_value(compare_pre),
		.active_value(compare_value)
	);

	dead_filter_tick_divider tick_divider (
		.hclk(hclk),
		.hresetn(hresetn),
		.divide_code(dead_filter_clock_divide),
		.tick(dead_filter_tick)
	);

	// Only haddr[7:0] decodes; the map repeats across the upper address bits.
	logic unused_bus;
	assign unused_bus = ^{haddr[31:8], hsize, htrans[0]};
endmodule
`default_nettype wire

// ===== verification/timer_control_assertions.sv
/*
 Checker for the timer control block, bound to its top module.
 Assumes zero-wait-state whole-word AHB-Lite writes on the register bus.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_control_assertions (
	// Clock, reset and bus.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Slave-mode controller.
	input wire logic encoder_mode_active,
	input wire logic trigger_start,
	input wire logic slave_update,
	// Timer outputs.
	input wire logic [15:0] counter_value,
	input wire logic count_down,
	input wire logic counter_update_event,
	input wire logic update_request,
	input wire logic channel_output,
	input wire logic dead_filter_tick
);
	// Only bits that software alone owns are mirrored, as hardware moves run and direction.
	logic aw, inh, urs, shot;
	logic [1:0] al, dv, lim;
	logic [3:0] age, gap;
	assign lim = (dv == 2'h0) ? 2'h0 : ((dv == 2'h1) ? 2'h1 : 2'h3);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aw <= 1'b0;
			{shot, urs, inh, al, dv} <= 7'h00;
			age <= 4'h0;
			gap <= 4'h0;
		end else begin
			aw <= hsel && htrans[1] && hready && hwrite && haddr[7:0] == 8'h00;
			age <= aw ? 4'h0 : ((age == 4'hf) ? age : age + 4'h1);
			gap <= dead_filter_tick ? 4'h0 : gap + 4'h1;
			if (aw) begin
				{shot, urs, inh} <= hwdata[3:1];
				al <= hwdata[6:5];
				if (hwdata[9:8] != 2'h3)
					dv <= hwdata[9:8];
			end
		end
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_inhibit;
		inh && $past(inh) |-> !counter_update_event;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("update while inhibited");
	property p_source;
		!urs && !$past(urs) |-> update_request == counter_update_event;
	endproperty
	a_source: assert property (p_source) else $error("request differs from update");
	property p_slave;
		slave_update && !inh |=> counter_update_event;
	endproperty
	a_slave: assert property (p_slave) else $error("slave update lost");
	property p_div;
		age == 4'hf |-> (dead_filter_tick ? gap[1:0] == lim && gap[3:2] == 2'h0 : gap < 4'(lim));
	endproperty
	a_div: assert property (p_div) else $error("tick spacing wrong");
	property p_one_shot;
		shot && $past(shot) && counter_update_event && !trigger_start
			|=> ($stable(counter_value) && $stable(channel_output))[*3];
	endproperty
	a_one_shot: assert property (p_one_shot) else $error("counter moved after one shot");
	property p_reset;
		$rose(hresetn) |-> counter_value == 16'h0000 && !count_down && !counter_update_event;
	endproperty
	a_reset: assert property (p_reset) else $error("state not cleared by reset");
	property p_dir;
		aw && al == 2'h0 && hwdata[6:5] == 2'h0 && !encoder_mode_active
			|=> count_down == $past(hwdata[4]);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not taken");
	property p_upper;
		hrdata[31:16] == 16'h0000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	c_one_shot: cover property (shot && counter_update_event);
	c_slave: cover property (slave_update && !inh);
	c_div_four: cover property (dv == 2'h2 && age == 4'hf && dead_filter_tick);
endmodule
bind timer_counter_control_one timer_control_assertions timer_control_assertions_i (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
	.encoder_mode_active, .trigger_start, .slave_update, .counter_value, .count_down,
	.counter_update_event, .update_request, .channel_output, .dead_filter_tick
);
`default_nettype wire

// ===== verification/tb.sv
/*
 Self-checking bench for the timer control block: bus reads go through a queue of
 expected words, and event counts are compared after the counting and update scenarios.
 Assumes the zero-wait-state bus and one counter step per clock with prescale zero.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import timer_control_pkg::*; ;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0, rd = 1'b0, down_q = 1'b0;
	logic trigger_mode_active = 1'b0, encoder_mode_active = 1'b0;
	logic trigger_start = 1'b0, slave_update = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout, count_down, counter_update_event, update_request, dead_filter_tick;
	logic compare_flag, channel_output;
	logic [31:0] expq[$];
	int failures = 0, n_compared = 0, n_ev = 0, n_rq = 0, n_tk = 0, n_rise = 0, cyc = 0;
	int n_cf = 0;
	int v = 0, r, r2, k, e0;
	timer_counter_control_one timer_counter_control_one_i (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hreadyout, .hresp(), .hrdata,
		.trigger_mode_active, .encoder_mode_active, .trigger_start, .slave_update,
		.counter_value(), .count_down, .counter_update_event, .update_request,
		.compare_flag, .channel_output, .dead_filter_tick
	);
	always #50 hclk = ~hclk;
	task automatic tally_and_finish();
		if (failures == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			failures++;
			$display("unexpected at %0t: got %h, want %h", $time, s, e);
		end
	endtask
	always @(posedge hclk) begin
		cyc <= cyc + 1;
		n_ev <= n_ev + int'(counter_update_event);
		n_rq <= n_rq + int'(update_request);
		n_tk <= n_tk + int'(dead_filter_tick);
		n_cf <= n_cf + int'(compare_flag);
		n_rise <= n_rise + int'(count_down && !down_q);
		down_q <= count_down;
		if (rd)
			chk(hrdata, expq.pop_front());
		if (cyc == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	// Two idle edges close every transfer, so a read never follows a write directly.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		rd <= !w;
		if (!w)
			expq.push_back(e);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd <= 1'b0;
		repeat (2) @(posedge hclk);
	endtask
	// Steps counted are k plus the four bus edges between start and stop. The first
	// wrap is an update unless inh is set, so a buffered reload rn takes over from there on.
	task automatic spin(input logic [31:0] c, input int k, rr, rn, inh);
		int s0;
		int c0;
		int n;
		int e;
		s0 = n_ev;
		c0 = n_cf;
		n = k + 4;
		e = 0;
		bus(1'b1, OFF_CONTROL_ONE, c | 32'h1, 32'h0);
		repeat (k) @(posedge hclk);
		bus(1'b1, OFF_CONTROL_ONE, c, 32'h0);
		if (v + n > rr) begin
			n = n - (rr + 1 - v);
			v = 0;
			e = 1;
			rr = inh ? rr : rn;
		end
		e = e + (v + n) / (rr + 1);
		v = (v + n) % (rr + 1);
		chk(n_ev - s0, inh ? 0 : e);
		chk(n_cf - c0, e);
		bus(1'b0, OFF_COUNTER, 32'h0, v);
	endtask
	task automatic upd(input bit sl, input int ee, er);
		int s0;
		int q0;
		s0 = n_ev;
		q0 = n_rq;
		if (sl) begin
			slave_update <= 1'b1;
			@(posedge hclk);
			slave_update <= 1'b0;
			repeat (3) @(posedge hclk);
		end else
			bus(1'b1, OFF_EVENT_GEN, 32'h1, 32'h0);
		chk(n_ev - s0, ee);
		chk(n_rq - q0, er);
		v = 0;
	endtask
	initial begin
		void'($urandom(96514));
		r = 3 + $urandom % 8;
		r2 = r + 1 + $urandom % 8;
		k = 20 + $urandom % 40;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'(CONTROL_ONE_RESET));
		bus(1'b0, OFF_RELOAD, 32'h0, 32'(RELOAD_RESET));
		bus(1'b0, 8'h08, 32'h0, 32'h0);
		for (int i = 0; i < 3; i++) begin
			bus(1'b1, OFF_CONTROL_ONE, i << 8, 32'h0);
			repeat (10) @(posedge hclk);
			e0 = n_tk;
			repeat (40) @(posedge hclk);
			chk(n_tk - e0, 40 >> i);
			bus(1'b0, OFF_CONTROL_ONE, 32'h0, i << 8);
		end
		bus(1'b1, OFF_CONTROL_ONE, 32'hffff_fb90, 32'h0);
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'h0290);
		encoder_mode_active <= 1'b1;
		bus(1'b1, OFF_CONTROL_ONE, 32'h0, 32'h0);
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'h0010);
		encoder_mode_active <= 1'b0;
		bus(1'b1, OFF_CONTROL_ONE, 32'h0, 32'h0);
		bus(1'b1, OFF_RELOAD, r, 32'h0);
		upd(1'b0, 1, 1);
		spin(32'h0, k, r, r, 0);
		bus(1'b1, OFF_CONTROL_ONE, 32'h80, 32'h0);
		bus(1'b1, OFF_RELOAD, r2, 32'h0);
		spin(32'h80, k, r, r2, 0);
		upd(1'b0, 1, 1);
		spin(32'h80, k, r2, r2, 0);
		bus(1'b1, OFF_CONTROL_ONE, 32'h84, 32'h0);
		upd(1'b0, 1, 0);
		upd(1'b1, 1, 0);
		bus(1'b1, OFF_CONTROL_ONE, 32'h0, 32'h0);
		upd(1'b1, 1, 1);
		spin(32'h2, k, r2, r2, 1);
		bus(1'b1, OFF_CONTROL_ONE, 32'h9, 32'h0);
		repeat (r2 + 4) @(posedge hclk);
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'h8);
		bus(1'b0, OFF_COUNTER, 32'h0, 32'h0);
		trigger_mode_active <= 1'b1;
		trigger_start <= 1'b1;
		@(posedge hclk);
		trigger_start <= 1'b0;
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'h9);
		repeat (r2 + 4) @(posedge hclk);
		bus(1'b0, OFF_CONTROL_ONE, 32'h0, 32'h8);
		trigger_mode_active <= 1'b0;
		for (int a = 1; a < 4; a++) begin
			bus(1'b1, OFF_CONTROL_ONE, 32'h0, 32'h0);
			bus(1'b1, OFF_CONTROL_ONE, 32'h0, 32'h0);
			bus(1'b1, OFF_CONTROL_ONE, a << 5, 32'h0);
			bus(1'b0, OFF_CONTROL_ONE, 32'h0, a << 5);
			e0 = n_rise;
			bus(1'b1, OFF_CONTROL_ONE, (a << 5) | 1, 32'h0);
			repeat (4 * r2 + 8) @(posedge hclk);
			bus(1'b1, OFF_CONTROL_ONE, a << 5, 32'h0);
			chk(n_rise > e0, 32'h1);
		end
		bus(1'b1, OFF_COMPARE, 32'hffff, 32'h0);
		chk(channel_output, 32'h0);
		upd(1'b0, 1, 1);
		chk(channel_output, 32'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
